// ---- logic/irrtx_pkg.sv ----
// irrtx_pkg: register map, field positions and reset values of the ir remote transmitter
package irrtx_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W  = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PULSE   = 8'h04;
  localparam logic [7:0] OFS_BITLEN  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;

  // bit_counter_control fields
  localparam int unsigned CTL_RUN     = 0;
  localparam int unsigned CTL_RESET   = 1;
  localparam int unsigned CTL_PRESET  = 2;
  localparam int unsigned CTL_COMPARE_BUFFER_ENABLE   = 3;
  localparam int unsigned CTL_ONESHOT = 4;

  // status_flag_reg fields: sticky events and read-only busy flags
  localparam int unsigned STS_AP      = 0;
  localparam int unsigned STS_DB      = 1;
  localparam int unsigned STS_AP_BUSY = 8;
  localparam int unsigned STS_DB_BUSY = 9;
  localparam int unsigned EVT_W       = 2;

  // reset values
  localparam logic [15:0] RST_LEN   = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0]  RST_EVT   = 2'h0;
  localparam logic [1:0]  RST_MASK  = 2'h0;

endpackage : irrtx_pkg

// ---- logic/irrtx_top.sv ----
// irrtx_top: compare buffers, data-bit counter and wishbone registers of the ir remote transmitter
module irrtx_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             ir_led_o
);

  // control state
  logic        counter_run_bit;
  logic        preset_bit;
  logic        compare_buffer_enable;
  logic        one_shot;
  logic [15:0] active_pulse_length;
  logic [15:0] data_bit_length;
  logic [15:0] pulse_buffer;
  logic [15:0] bit_buffer;
  logic        pulse_length_busy;
  logic        bit_length_busy;
  logic [15:0] bit_counter_value;
  logic [1:0]  event_flags;
  logic [1:0]  event_mask;

  // bus decode
  wire         bus_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire         bus_wr       = bus_req && wb_we_i;
  wire         sel_control  = (wb_adr_i == irrtx_pkg::OFS_CONTROL);
  wire         sel_pulse    = (wb_adr_i == irrtx_pkg::OFS_PULSE);
  wire         sel_bitlen   = (wb_adr_i == irrtx_pkg::OFS_BITLEN);
  wire         sel_count    = (wb_adr_i == irrtx_pkg::OFS_COUNT);
  wire         sel_status   = (wb_adr_i == irrtx_pkg::OFS_STATUS);
  wire         sel_mask     = (wb_adr_i == irrtx_pkg::OFS_MASK);
  wire         wr_ctl_lo    = bus_wr && sel_control && wb_sel_i[0];
  wire         wr_status    = bus_wr && sel_status && wb_sel_i[0];
  wire         wr_mask      = bus_wr && sel_mask && wb_sel_i[0];

  // byte-lane merge of a 16-bit length field
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  wire         len_lanes    = wb_sel_i[0] || wb_sel_i[1];
  wire         wr_pulse     = bus_wr && sel_pulse && len_lanes && !pulse_length_busy;
  wire         wr_bitlen    = bus_wr && sel_bitlen && len_lanes && !bit_length_busy;

  // software reset: a one written to the counter reset bit
  wire         soft_reset   = wr_ctl_lo && wb_dat_i[irrtx_pkg::CTL_RESET];
  wire         preset_req   = wr_ctl_lo && wb_dat_i[irrtx_pkg::CTL_PRESET];

  wire  [15:0] eff_pulse    = compare_buffer_enable ? pulse_buffer : active_pulse_length;
  wire  [15:0] eff_bitlen   = compare_buffer_enable ? bit_buffer : data_bit_length;

  wire         active_pulse_compare = counter_run_bit && (bit_counter_value == eff_pulse);
  wire         data_bit_compare     = counter_run_bit && (bit_counter_value == eff_bitlen);

  // buffers reload at the end of each data bit, on preset, or at once while idle,
  // so with compare buffers enabled a new length never disturbs the bit that is already being sent
  wire         load_buffers = data_bit_compare || preset_req || !counter_run_bit;
  // one-shot stops after one data bit; the same end of bit also clears the counter
  wire         one_shot_end = data_bit_compare && one_shot;

  wire  [1:0]  new_events   = {data_bit_compare, active_pulse_compare};
  wire  [1:0]  clear_events = wr_status ?
                              wb_dat_i[irrtx_pkg::STS_DB:irrtx_pkg::STS_AP] : 2'h0;
  // set wins over a simultaneous write-one-to-clear
  wire  [1:0]  next_events  = (event_flags & ~clear_events) | new_events;
  wire  [1:0]  next_mask    = wr_mask ?
                              wb_dat_i[irrtx_pkg::STS_DB:irrtx_pkg::STS_AP] : event_mask;

  wire         next_run     = soft_reset ? 1'b0 :
                              wr_ctl_lo ? (wb_dat_i[irrtx_pkg::CTL_RUN] && !wb_dat_i[irrtx_pkg::CTL_RESET]) :
                              one_shot_end ? 1'b0 : counter_run_bit;

  // counter cleared by soft reset, preset or end of bit
  wire  [15:0] next_count   = (soft_reset || preset_req || data_bit_compare) ? irrtx_pkg::RST_COUNT :
                              counter_run_bit ? bit_counter_value + 16'h0001 : bit_counter_value;

  // busy set on write with buffers on
  // busy cleared on transfer, set wins
  wire         next_pulse_busy = compare_buffer_enable &&
                                 ((wr_pulse) || (pulse_length_busy && !load_buffers));
  wire         next_bit_busy   = compare_buffer_enable &&
                                 ((wr_bitlen) || (bit_length_busy && !load_buffers));

  // read mux
  wire  [31:0] status_word  = {22'h000000, bit_length_busy, pulse_length_busy, 6'h00, event_flags};
  wire  [31:0] control_word = {27'h0000000, one_shot, compare_buffer_enable, preset_bit, 1'b0, counter_run_bit};
  // busy flags read meaningfully only with buffers enabled
  wire  [31:0] next_rdata   = sel_control ? control_word :
                              sel_pulse   ? {16'h0000, active_pulse_length} :
                              sel_bitlen  ? {16'h0000, data_bit_length} :
                              sel_count   ? {16'h0000, bit_counter_value} :
                              sel_status  ? status_word :
                              sel_mask    ? {30'h00000000, event_mask} : 32'h00000000;

  wire         next_led     = next_run && (next_count < eff_pulse);

  // bus answer: every access acked one cycle after it is seen, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdata : wb_dat_o;
    end
  end

  // run and preset cleared by both resets
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      counter_run_bit       <= 1'b0;
      preset_bit            <= 1'b0;
      compare_buffer_enable <= 1'b0;
      one_shot              <= 1'b0;
    end
    else
    begin
      counter_run_bit <= next_run;
      preset_bit      <= 1'b0;
      if (wr_ctl_lo && !soft_reset)
      begin
        compare_buffer_enable <= wb_dat_i[irrtx_pkg::CTL_COMPARE_BUFFER_ENABLE];
        one_shot              <= wb_dat_i[irrtx_pkg::CTL_ONESHOT];
      end
    end
  end

  // length registers and compare buffers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_pulse_length <= irrtx_pkg::RST_LEN;
      data_bit_length     <= irrtx_pkg::RST_LEN;
      pulse_buffer        <= irrtx_pkg::RST_LEN;
      bit_buffer          <= irrtx_pkg::RST_LEN;
    end
    else
    begin
      if (wr_pulse)
      begin
        active_pulse_length <= merge16(active_pulse_length, wb_dat_i, wb_sel_i);
      end
      if (wr_bitlen)
      begin
        data_bit_length <= merge16(data_bit_length, wb_dat_i, wb_sel_i);
      end
      if (load_buffers)
      begin
        pulse_buffer <= active_pulse_length;
        bit_buffer   <= data_bit_length;
      end
    end
  end

  // busy flags and counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pulse_length_busy <= 1'b0;
      bit_length_busy   <= 1'b0;
      bit_counter_value <= irrtx_pkg::RST_COUNT;
    end
    else
    begin
      pulse_length_busy <= next_pulse_busy;
      bit_length_busy   <= next_bit_busy;
      bit_counter_value <= next_count;
    end
  end

  // events, mask, interrupt and led drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      event_flags <= irrtx_pkg::RST_EVT;
      event_mask  <= irrtx_pkg::RST_MASK;
      irq_o       <= 1'b0;
      ir_led_o    <= 1'b0;
    end
    else
    begin
      event_flags <= next_events;
      event_mask  <= next_mask;
      irq_o       <= |(next_events & next_mask);
      ir_led_o    <= next_led;
    end
  end

endmodule // irrtx_top

// ---- tb/irrtx_checker.sv ----
// irrtx_checker: port-level assertions for the ir remote transmitter
module irrtx_checker
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        irq_o,
  input  wire logic        ir_led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd  = req && !wb_we_i;
  a_ack_follows_req: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_no_stray_ack: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  a_quiet_after_reset: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !ir_led_o)
    else $error("outputs active after reset");
  a_read_data_holds: assert property (!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_len_upper_zero: assert property (rd && wb_adr_i inside {8'h04, 8'h08, 8'h0C} |=> wb_dat_o[31:16] == 16'h0000)
    else $error("length upper bits set");
  a_unmapped_reads_zero: assert property (rd && wb_adr_i > 8'h14 |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_ctl_strobes_zero: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o[2:1] == 2'h0)
    else $error("reset or preset bit reads one");
  c_read: cover property (rd ##1 wb_ack_o);
  c_irq: cover property ($rose(irq_o));
  c_led: cover property ($fell(ir_led_o));
endmodule // irrtx_checker

bind irrtx_top irrtx_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .ir_led_o(ir_led_o));

// ---- tb/irrtx_led_model.sv ----
// irrtx_led_model: infrared led module, measures the width of each emitted pulse
module irrtx_led_model
(
  input  wire logic clk_i,
  input  wire logic led_i,
  output int        width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int run_len = 0;
  always @(posedge clk_i)
  begin
    if (led_i)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      width_o <= run_len;
      run_len <= 0;
    end
  end
endmodule // irrtx_led_model

// ---- tb/tb_ir_remote_compare_buffer.sv ----
// tb_ir_remote_compare_buffer: scenario bench for the ir remote transmitter
module tb_ir_remote_compare_buffer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, irq, led;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, dat_o;
  int          n_errors = 0, tests_run = 0, width;
  always #5 clk_i = ~clk_i;
  irrtx_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .ir_led_o(led));
  irrtx_led_model u_led (.clk_i(clk_i), .led_i(led), .width_o(width));
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // ack is read at the edge itself, before that edge's updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    chk("ack", 1, {31'h0, ack});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(0, a, 0);
    chk(what, exp, rdat);
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  task automatic t_reset;
    rd(8'h00, 0, "control");
    rd(8'h0C, 0, "count");
    rd(8'h1C, 0, "unmapped");
  endtask
  task automatic t_direct;
    bus(1, 8'h04, 3);
    bus(1, 8'h08, 5);
    bus(1, 8'h14, 3);
    bus(1, 8'h00, 1);
    repeat (20) @(posedge clk_i);
    chk("led width", 3, 32'(width));
    irq_is(1);
    bus(1, 8'h14, 0);
    irq_is(0);
    bus(1, 8'h00, 2);
    rd(8'h00, 0, "control");
    rd(8'h0C, 0, "count");
    rd(8'h10, 3, "status");
    bus(1, 8'h14, 3);
    irq_is(1);
    bus(1, 8'h10, 3);
    rd(8'h10, 0, "status cleared");
    irq_is(0);
  endtask
  task automatic t_buffered;
    bus(1, 8'h08, 40);
    bus(1, 8'h00, 8);
    bus(1, 8'h00, 9);
    repeat (10) @(posedge clk_i);
    bus(1, 8'h04, 30);
    rd(8'h10, 32'h101, "busy set");
    bus(1, 8'h04, 9);
    rd(8'h04, 30, "pulse length");
    repeat (20) @(posedge clk_i);
    chk("old width", 3, 32'(width));
    bus(0, 8'h10, 0);
    chk("busy clear", 0, rdat & 32'h300);
    repeat (40) @(posedge clk_i);
    chk("new width", 30, 32'(width));
    bus(1, 8'h00, 2);
  endtask
  // hardware reset in mid-run: run, counter and events must all be cleared
  task automatic t_midreset;
    bus(1, 8'h00, 1);
    repeat (7) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("led in reset", 0, {31'h0, led});
    rd(8'h00, 0, "control after reset");
    rd(8'h0C, 0, "count after reset");
    rd(8'h10, 0, "status after reset");
    chk("irq after reset", 0, {31'h0, irq});
  endtask
  initial
  begin
    #200000;
    n_errors++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_direct;
    t_buffered;
    t_midreset;
    stop_test;
  end
endmodule // tb_ir_remote_compare_buffer
